// [sie_pkg.sv]
// constants, field layouts and state codes for the subtract execution unit
// assumes a single 100 MHz clock domain shared by all users
package sie_pkg;
  // ---------------------------------------------------------------
  // register offsets on the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_ACC    = 4'h0;
  localparam logic [3:0] ADDR_BANK   = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CTRL   = 4'h3;
  // ---------------------------------------------------------------
  // status and control bit positions
  // ---------------------------------------------------------------
  localparam int ST_C   = 0;
  localparam int ST_DC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_OV  = 3;
  localparam int ST_N   = 4;
  localparam int CTRL_EXT = 0;
  // ---------------------------------------------------------------
  // opcode patterns and addressing constants
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_LIT     = 8'h08;  // 0000 1000 kkkk kkkk
  localparam logic [5:0] OPC_MEM     = 6'h17;  // 0101 11da ffff ffff
  localparam int         BIT_DEST    = 9;
  localparam int         BIT_ACCESS  = 8;
  localparam logic [7:0] ILO_LIMIT   = 8'h5f;  // 95
  localparam logic [3:0] ACC_BANK_LO = 4'h0;
  localparam logic [3:0] ACC_BANK_HI = 4'hf;
  localparam logic [7:0] ACC_SPLIT   = 8'h60;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ACC    = 8'h00;
  localparam logic [3:0] RST_BANK   = 4'h0;
  localparam logic [4:0] RST_STATUS = 5'h00;
  localparam logic [0:0] RST_CTRL   = 1'h0;
  // ---------------------------------------------------------------
  // instruction cycle phases
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SIE_IDLE   = 5'b00001,
    SIE_DECODE = 5'b00010,
    SIE_READ   = 5'b00100,
    SIE_PROC   = 5'b01000,
    SIE_WRITE  = 5'b10000
  } sie_state_t;
endpackage : sie_pkg

// [sie_exec.sv]
// subtract execution unit: literal-minus-accumulator and byte-minus-accumulator
// assumes data memory answers a read strobe with data in the same cycle
`timescale 1ns/1ps
module sie_exec #(
  parameter int AW = 12  // data memory address width
) (
  input  wire logic          clk,          // 100 MHz clock
  input  wire logic          sys_rst,      // synchronous reset, high
  input  wire logic [3:0]    reg_addr,     // register offset
  input  wire logic [7:0]    reg_wdata,    // register write data
  input  wire logic          reg_we,       // register write strobe
  input  wire logic          reg_re,       // register read strobe
  output      logic [7:0]    reg_rdata,    // read data, cycle after strobe
  input  wire logic [15:0]   instr,        // instruction word
  input  wire logic          instr_valid,  // instruction offered
  output      logic          instr_ready,  // unit idle, takes instr
  output      logic          instr_done,   // pulse at write phase
  output      logic          instr_bad,    // pulse, word not a subtract
  input  wire logic [AW-1:0] idx_base,     // index base for offset mode
  output      logic [AW-1:0] mem_addr,     // data memory address
  output      logic          mem_rd,       // data memory read strobe
  input  wire logic [7:0]    mem_rdata,    // read data, same cycle as mem_rd
  output      logic          mem_wr,       // data memory write strobe
  output      logic [7:0]    mem_wdata     // data memory write data
);
  // ---------------------------------------------------------------
  // architectural state
  // ---------------------------------------------------------------
  sie_pkg::sie_state_t state;
  logic [7:0]    acc;
  logic [3:0]    bank_ptr;
  logic [4:0]    status;
  logic [0:0]    ctrl;
  logic [15:0]   ir;
  logic [7:0]    minuend;
  logic [7:0]    result;
  logic [4:0]    next_flags;
  logic [AW-1:0] next_addr;
  logic          is_lit;
  logic          is_mem;
  logic [8:0]    diff9;
  logic [4:0]    diff5;

  assign is_lit = (ir[15:8] == sie_pkg::OPC_LIT);
  assign is_mem = (ir[15:10] == sie_pkg::OPC_MEM);
  assign instr_ready = state[0];

  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  always_comb begin
    if (ir[sie_pkg::BIT_ACCESS]) begin
      next_addr = AW'({bank_ptr, ir[7:0]});
    end else if (ctrl[sie_pkg::CTRL_EXT] && ir[7:0] <= sie_pkg::ILO_LIMIT) begin
      next_addr = idx_base + AW'(ir[7:0]);
    end else if (ir[7:0] < sie_pkg::ACC_SPLIT) begin
      next_addr = AW'({sie_pkg::ACC_BANK_LO, ir[7:0]});
    end else begin
      next_addr = AW'({sie_pkg::ACC_BANK_HI, ir[7:0]});
    end
  end

  // ---------------------------------------------------------------
  // subtractor and flags
  // ---------------------------------------------------------------
  // add of the inverted subtrahend plus one gives carry as not-borrow
  assign diff9 = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
  assign diff5 = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  always_comb begin
    next_flags = '0;
    next_flags[sie_pkg::ST_C]  = diff9[8];
    next_flags[sie_pkg::ST_DC] = diff5[4];
    next_flags[sie_pkg::ST_Z]  = (diff9[7:0] == 8'h00);
    next_flags[sie_pkg::ST_OV] = (minuend[7] ^ acc[7]) & (minuend[7] ^ diff9[7]);
    next_flags[sie_pkg::ST_N]  = diff9[7];
  end

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= sie_pkg::SIE_IDLE;
    end else begin
      case (state)
        sie_pkg::SIE_IDLE:   if (instr_valid) state <= sie_pkg::SIE_DECODE;
        sie_pkg::SIE_DECODE: state <= (is_lit || is_mem) ? sie_pkg::SIE_READ : sie_pkg::SIE_IDLE;
        sie_pkg::SIE_READ:   state <= sie_pkg::SIE_PROC;
        sie_pkg::SIE_PROC:   state <= sie_pkg::SIE_WRITE;
        sie_pkg::SIE_WRITE:  state <= sie_pkg::SIE_IDLE;
        default:             state <= sie_pkg::SIE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir <= 16'h0000;
    end else if (state == sie_pkg::SIE_IDLE && instr_valid) begin
      ir <= instr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_bad <= 1'b0;
    end else begin
      instr_bad <= (state == sie_pkg::SIE_DECODE) && !is_lit && !is_mem;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= (state == sie_pkg::SIE_PROC);
    end
  end

  // ---------------------------------------------------------------
  // operand fetch and result capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_rd   <= 1'b0;
      mem_addr <= '0;
    end else begin
      mem_rd <= (state == sie_pkg::SIE_DECODE) && is_mem;
      if (state == sie_pkg::SIE_DECODE) mem_addr <= next_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      minuend <= 8'h00;
    end else if (state == sie_pkg::SIE_READ) begin
      minuend <= is_lit ? ir[7:0] : mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result <= 8'h00;
    end else if (state == sie_pkg::SIE_PROC) begin
      result <= diff9[7:0];
    end
  end

  // ---------------------------------------------------------------
  // write-back
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= (state == sie_pkg::SIE_PROC) && is_mem && ir[sie_pkg::BIT_DEST];
      if (state == sie_pkg::SIE_PROC) mem_wdata <= diff9[7:0];
    end
  end

  // engine write beats a software write landing in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc <= sie_pkg::RST_ACC;
    end else if (state == sie_pkg::SIE_WRITE && (is_lit || !ir[sie_pkg::BIT_DEST])) begin
      acc <= result;
    end else if (reg_we && reg_addr == sie_pkg::ADDR_ACC) begin
      acc <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status <= sie_pkg::RST_STATUS;
    end else if (state == sie_pkg::SIE_PROC) begin
      status <= next_flags;
    end else if (reg_we && reg_addr == sie_pkg::ADDR_STATUS) begin
      status <= reg_wdata[4:0];
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_ptr <= sie_pkg::RST_BANK;
      ctrl     <= sie_pkg::RST_CTRL;
    end else if (reg_we) begin
      if (reg_addr == sie_pkg::ADDR_BANK) bank_ptr <= reg_wdata[3:0];
      else if (reg_addr == sie_pkg::ADDR_CTRL) ctrl <= reg_wdata[0:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      if (reg_addr == sie_pkg::ADDR_ACC) reg_rdata <= acc;
      else if (reg_addr == sie_pkg::ADDR_BANK) reg_rdata <= {4'h0, bank_ptr};
      else if (reg_addr == sie_pkg::ADDR_STATUS) reg_rdata <= {3'h0, status};
      else if (reg_addr == sie_pkg::ADDR_CTRL) reg_rdata <= {7'h00, ctrl};
      else reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_lit_into_acc: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sie_pkg::SIE_PROC && is_lit) |=> (!mem_wr ##1 acc == $past(ir[7:0], 2) - $past(acc, 2)))
    else $error("literal result not in accumulator");
  a_mem_read_op: assert property (@(posedge clk) disable iff (sys_rst)
    mem_rd |-> (state == sie_pkg::SIE_READ && is_mem))
    else $error("operand read outside read phase");
  a_dest_acc: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sie_pkg::SIE_WRITE && is_mem && !ir[sie_pkg::BIT_DEST]) |-> (!mem_wr ##1 acc == $past(result)))
    else $error("accumulator destination wrong");
  a_dest_mem: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sie_pkg::SIE_PROC && is_mem && ir[sie_pkg::BIT_DEST]) |=>
      (mem_wr && mem_wdata == $past(minuend) - $past(acc) ##1 $stable(acc)))
    else $error("memory destination wrong");
  a_bank_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (mem_rd && ir[sie_pkg::BIT_ACCESS]) |-> mem_addr == AW'({bank_ptr, ir[7:0]}))
    else $error("banked address wrong");
  a_offset_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (mem_rd && !ir[sie_pkg::BIT_ACCESS] && ctrl[sie_pkg::CTRL_EXT] && ir[7:0] <= sie_pkg::ILO_LIMIT)
      |-> mem_addr == idx_base + AW'(ir[7:0]))
    else $error("indexed offset address wrong");
  a_access_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (mem_rd && !ir[sie_pkg::BIT_ACCESS] && !(ctrl[sie_pkg::CTRL_EXT] && ir[7:0] <= sie_pkg::ILO_LIMIT))
      |-> mem_addr == AW'({((ir[7:0] < sie_pkg::ACC_SPLIT) ? sie_pkg::ACC_BANK_LO : sie_pkg::ACC_BANK_HI), ir[7:0]}))
    else $error("access bank address wrong");
  a_carry_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sie_pkg::SIE_PROC) |=> (status[sie_pkg::ST_C] == ($past(minuend) >= $past(acc))
      && status[sie_pkg::ST_Z] == ($past(minuend) == $past(acc))))
    else $error("carry or zero flag wrong");
  a_phase_order: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sie_pkg::SIE_DECODE && (is_lit || is_mem)) |=>
      state == sie_pkg::SIE_READ ##1 state == sie_pkg::SIE_PROC ##1 state == sie_pkg::SIE_WRITE ##1 instr_ready)
    else $error("phase order broken");
  a_nibble_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (state == sie_pkg::SIE_PROC) |=> status[sie_pkg::ST_DC] == ($past(minuend[3:0]) >= $past(acc[3:0])))
    else $error("nibble carry flag wrong");
endmodule : sie_exec

// [testbench.sv]
// self-checking bench for the subtract execution unit
// assumes a 100 MHz clock; the bench models data memory itself
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [7:0]  reg_rdata;
  logic [15:0] instr;
  logic        instr_valid;
  logic        instr_ready;
  logic        instr_done;
  logic        instr_bad;
  logic [11:0] idx_base;
  logic [11:0] mem_addr;
  logic        mem_rd;
  logic [7:0]  mem_rdata;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem [0:4095];
  int          err_count;
  int          num_checks;

  sie_exec #(.AW(12)) i_sie_exec (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_done(instr_done),
    .instr_bad(instr_bad), .idx_base(idx_base), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata)
  );

  // ---------------------------------------------------------------
  // clock and data memory
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // same-cycle read data, only while the strobe is up, so a lost strobe shows
  assign mem_rdata = mem_rd ? mem[mem_addr] : 8'h00;
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd

  // offers one word, returns edges from the taking edge to done or bad, both edges counted
  task automatic exec(input logic [15:0] w, output int n);
    n = 1;
    @(posedge clk);
    instr       <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    check("ready_busy", {15'h0, instr_ready}, 16'h0);
    while (instr_done !== 1'b1 && instr_bad !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1 n++;
    end
    repeat (2) @(posedge clk);
    check("ready_idle", {15'h0, instr_ready}, 16'h1);
  endtask : exec

  function automatic logic [7:0] flags(input logic [7:0] m, input logic [7:0] w);
    logic [7:0] r;
    r = m - w;
    return {3'h0, r[7], (m[7] != w[7]) && (r[7] != m[7]), r == 8'h00, m[3:0] >= w[3:0], m >= w};
  endfunction : flags

  task automatic do_lit(input logic [7:0] k, input logic [7:0] w);
    int         n;
    logic [7:0] d;
    reg_wr(sie_pkg::ADDR_ACC, w);
    exec({sie_pkg::OPC_LIT, k}, n);
    check("lit_cycles", 16'(n), 16'h4);
    reg_rd(sie_pkg::ADDR_ACC, d);
    check("lit_acc", {8'h0, d}, {8'h0, k - w});
    reg_rd(sie_pkg::ADDR_STATUS, d);
    check("lit_status", {8'h0, d}, {8'h0, flags(k, w)});
  endtask : do_lit

  task automatic do_byte(input logic ext, input logic [3:0] bk, input logic dst, input logic acs,
                         input logic [7:0] f, input logic [11:0] ea, input logic [7:0] mv, input logic [7:0] w);
    int         n;
    logic [7:0] d;
    reg_wr(sie_pkg::ADDR_CTRL, {7'h0, ext});
    reg_wr(sie_pkg::ADDR_BANK, {4'h0, bk});
    reg_wr(sie_pkg::ADDR_ACC, w);
    mem[ea] = mv;
    exec({sie_pkg::OPC_MEM, dst, acs, f}, n);
    check("byte_cycles", 16'(n), 16'h4);
    check("byte_mem", {8'h0, mem[ea]}, {8'h0, dst ? mv - w : mv});
    reg_rd(sie_pkg::ADDR_ACC, d);
    check("byte_acc", {8'h0, d}, {8'h0, dst ? w : mv - w});
    reg_rd(sie_pkg::ADDR_STATUS, d);
    check("byte_status", {8'h0, d}, {8'h0, flags(mv, w)});
  endtask : do_byte

  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    int         n;
    logic [7:0] d;
    err_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    {reg_addr, reg_wdata, reg_we, reg_re, instr, instr_valid} = '0;
    idx_base = 12'h200;
    // fill distinct within each 256-byte block, so a wrong low address byte reads a wrong byte
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'ha5;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      reg_rd(4'(a), d);
      check("reset_reg", {8'h0, d}, 16'h0);
    end
    reg_wr(4'h7, 8'hff);
    reg_rd(4'h7, d);
    check("unmapped", {8'h0, d}, 16'h0);
    $display("test registers done");
    do_lit(8'h02, 8'h01);
    do_lit(8'h02, 8'h02);
    do_lit(8'h02, 8'h03);
    do_lit(8'h80, 8'h01);
    do_lit(8'h10, 8'h0f);
    $display("test literal form done");
    do_byte(1'b0, 4'h3, 1'b1, 1'b1, 8'h45, 12'h345, 8'h03, 8'h02);
    do_byte(1'b0, 4'h3, 1'b0, 1'b0, 8'h10, 12'h010, 8'h02, 8'h02);
    do_byte(1'b0, 4'h3, 1'b1, 1'b0, 8'ha0, 12'hfa0, 8'h01, 8'h02);
    do_byte(1'b1, 4'h3, 1'b1, 1'b0, 8'h5f, 12'h25f, 8'h90, 8'h20);
    do_byte(1'b1, 4'h3, 1'b0, 1'b0, 8'h60, 12'hf60, 8'h7f, 8'hff);
    do_byte(1'b1, 4'h5, 1'b1, 1'b1, 8'h05, 12'h505, 8'h44, 8'h44);
    $display("test byte form done");
    reg_wr(sie_pkg::ADDR_ACC, 8'h3c);
    exec(16'hffff, n);
    check("bad_cycles", 16'(n), 16'h2);
    reg_rd(sie_pkg::ADDR_ACC, d);
    check("bad_acc", {8'h0, d}, 16'h3c);
    $display("test undefined word done");
    close_out();
  end
endmodule : testbench
